// ==== hdl/bsp_pkg.sv ====
// Package: constants, types and helpers for BLDC start-up and protection
package bsp_pkg;

    // Clock and supervision tick
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;

    // Supervision times, expressed in ticks
    localparam int unsigned TIMEOUT_MS    = 200;
    localparam int unsigned TIMEOUT_TICKS = TIMEOUT_MS / TICK_MS;
    localparam int unsigned ALIGN_MS      = 100;
    localparam int unsigned ALIGN_TICKS   = ALIGN_MS / TICK_MS;
    localparam int unsigned OL_STEP_MS    = 20;
    localparam int unsigned OL_STEP_TICKS = OL_STEP_MS / TICK_MS;
    localparam int unsigned ZC_TO_CLOSE   = 3;

    // Per-unit fixed point: Q4.12, base voltage is the rated voltage
    localparam int unsigned PU_FRAC       = 12;
    localparam int unsigned PU_ONE        = 1 << PU_FRAC;
    localparam int unsigned V_BASE_V      = 24;
    localparam int unsigned OV_LIMIT_V    = 28;
    localparam int unsigned UV_LIMIT_V    = 15;
    localparam logic [15:0] OV_LIMIT_PU   = 16'(OV_LIMIT_V * PU_ONE / V_BASE_V);
    localparam logic [15:0] UV_LIMIT_PU   = 16'(UV_LIMIT_V * PU_ONE / V_BASE_V);

    // Overspeed as the shortest legal 60-degree step period in clock cycles
    localparam int unsigned POLE_PAIRS    = 2;
    localparam int unsigned OVERSPEED_RPM = 3900;
    localparam int unsigned OS_STEP_CYC   = CLK_HZ * 60 / (6 * POLE_PAIRS * OVERSPEED_RPM);

    // Widths
    localparam int unsigned DUTY_W        = 10;
    localparam int unsigned PER_W         = 24;

    // Error flag positions
    localparam int unsigned ERR_OC        = 0;
    localparam int unsigned ERR_OV        = 1;
    localparam int unsigned ERR_UV        = 2;
    localparam int unsigned ERR_SPD       = 3;
    localparam int unsigned ERR_TO        = 4;
    localparam int unsigned ERR_PAT       = 5;
    localparam int unsigned ERR_DRV       = 6;
    localparam int unsigned ERR_W         = 7;

    // Reset step value and illegal-step marker
    localparam logic [2:0]  STEP_RST      = 3'h0;
    localparam logic [2:0]  STEP_BAD      = 3'h7;

    typedef enum logic [2:0] {
        SYS_INACTIVE = 3'b001,
        SYS_ACTIVE   = 3'b010,
        SYS_ERROR    = 3'b100
    } bsp_sys_t;

    typedef enum logic [2:0] {
        PH_ALIGN  = 3'b001,
        PH_OPEN   = 3'b010,
        PH_CLOSED = 3'b100
    } bsp_phase_t;

    // Six inverter gate enables
    typedef struct packed {
        logic uh;
        logic ul;
        logic vh;
        logic vl;
        logic wh;
        logic wl;
    } bsp_gate_t;

    // Hall code to step; codes 0 and 7 are illegal
    function automatic logic [2:0] hall_to_step(input logic [2:0] h);
        case (h)
            3'h5:    hall_to_step = 3'h0;
            3'h1:    hall_to_step = 3'h1;
            3'h3:    hall_to_step = 3'h2;
            3'h2:    hall_to_step = 3'h3;
            3'h6:    hall_to_step = 3'h4;
            3'h4:    hall_to_step = 3'h5;
            default: hall_to_step = STEP_BAD;
        endcase
    endfunction : hall_to_step

    function automatic logic [2:0] step_inc(input logic [2:0] s);
        step_inc = (s >= 3'h5) ? 3'h0 : 3'(s + 3'h1);
    endfunction : step_inc

    function automatic logic [2:0] step_dec(input logic [2:0] s);
        step_dec = (s == 3'h0 || s > 3'h5) ? 3'h5 : 3'(s - 3'h1);
    endfunction : step_dec

    // One high and one low switch per step
    function automatic bsp_gate_t step_gates(input logic [2:0] s);
        case (s)
            3'h0:    step_gates = 6'h24;
            3'h1:    step_gates = 6'h21;
            3'h2:    step_gates = 6'h09;
            3'h3:    step_gates = 6'h18;
            3'h4:    step_gates = 6'h12;
            3'h5:    step_gates = 6'h06;
            default: step_gates = 6'h00;
        endcase
    endfunction : step_gates

endpackage : bsp_pkg

// ==== hdl/bsp_moddiv.sv ====
// Modulation factor divider: duty = vcmd / vbus, scaled to full duty
`timescale 1ns/100ps
module bsp_moddiv
    import bsp_pkg::*;
#(
    parameter int unsigned DW = DUTY_W
)(
    input  logic          clk,
    input  logic          rst,
    input  logic          ce,
    input  logic          start,
    input  logic [15:0]   num,
    input  logic [15:0]   den,
    output logic [DW-1:0] duty
);
    localparam int unsigned CW = $clog2(DW + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
        logic [15:0]   rem;
        logic [15:0]   den;
        logic [DW-1:0] q;
        logic [DW-1:0] duty;
    } bsp_div_t;

    bsp_div_t   st;
    bsp_div_t   nx;
    logic [16:0] trial;

    // Restoring division, one quotient bit per cycle; over-range saturates
    always_comb
    begin
        nx    = st;
        trial = {st.rem, 1'b0};
        if (start)
        begin
            if (den == 16'h0000 || num >= den)
            begin
                nx.busy = 1'b0;
                nx.duty = '1;
            end
            else
            begin
                nx.busy = 1'b1;
                nx.rem  = num;
                nx.den  = den;
                nx.q    = '0;
                nx.cnt  = CW'(DW);
            end
        end
        else if (st.busy)
        begin
            if (trial >= {1'b0, st.den})
            begin
                nx.rem = 16'(trial - {1'b0, st.den});
                nx.q   = {st.q[DW-2:0], 1'b1};
            end
            else
            begin
                nx.rem = trial[15:0];
                nx.q   = {st.q[DW-2:0], 1'b0};
            end
            nx.cnt = CW'(st.cnt - 1'b1);
            if (st.cnt == CW'(1))
            begin
                nx.busy = 1'b0;
                nx.duty = nx.q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else if (ce)
            st <= nx;
    end

    assign duty = st.duty;

    a_div_saturate: assert property (@(posedge clk) disable iff (rst)
        (ce && start && den != 16'h0000 && num >= den) |=> (duty == '1))
        else $error("modulation did not saturate");

endmodule : bsp_moddiv

// ==== hdl/bsp_supervisor.sv ====
// Top: start-up sequencing and protection supervisor for six-step drive
`timescale 1ns/100ps
module bsp_supervisor
    import bsp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES    = TICK_CYC,
    parameter int unsigned OS_STEP_CYCLES = OS_STEP_CYC
)(
    input  logic              clk,
    input  logic              rst,
    input  logic              ce,
    input  logic              sensorless_mode,
    input  logic              drive_cmd,
    input  logic              stop_cmd,
    input  logic              reset_cmd,
    input  logic [2:0]        hall_in,
    input  logic              zc_pulse,
    input  logic              oc_stop_n,
    input  logic              drv_fault,
    input  logic [15:0]       vbus_pu,
    input  logic [15:0]       vcmd_pu,
    output bsp_gate_t         gates,
    output logic [DUTY_W-1:0] duty,
    output bsp_sys_t          sys_state,
    output bsp_phase_t        ctl_phase,
    output logic [ERR_W-1:0]  err_flags,
    output logic              speed_valid,
    output logic [PER_W-1:0]  step_period
);
    typedef struct packed {
        logic [2:0]        hall_s1;
        logic [2:0]        hall_s2;
        logic [2:0]        hall_prev;
        logic              oc_n_s1;
        logic              oc_n_s2;
        logic              flt_s1;
        logic              flt_s2;
        bsp_sys_t          sys;
        bsp_phase_t        phase;
        logic [2:0]        step;
        bsp_gate_t         gates;
        logic [15:0]       tick_cnt;
        logic              tick;
        logic [7:0]        to_cnt;
        logic [7:0]        ph_cnt;
        logic [1:0]        zc_cnt;
        logic [1:0]        evt_cnt;
        logic [PER_W-1:0]  per_cnt;
        logic [PER_W-1:0]  step_period;
        logic              speed_valid;
        logic [ERR_W-1:0]  err;
        logic [DUTY_W-1:0] duty;
    } bsp_st_t;

    bsp_st_t           st;
    bsp_st_t           nx;
    logic [2:0]        hall_step;
    logic              evt;
    logic [ERR_W-1:0]  new_err;
    logic [DUTY_W-1:0] div_duty;

    // Duty recomputed once per tick from the latest command and bus
    bsp_moddiv #(
        .DW    (DUTY_W)
    ) u_div (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .start (st.tick),
        .num   (vcmd_pu),
        .den   (vbus_pu),
        .duty  (div_duty)
    );

    // Next-state logic for the whole supervisor
    always_comb
    begin
        nx        = st;
        hall_step = hall_to_step(st.hall_s2);
        evt       = 1'b0;
        new_err   = '0;

        // Pin synchronisers; first stage feeds only the second
        nx.hall_s1   = hall_in;
        nx.hall_s2   = st.hall_s1;
        nx.hall_prev = st.hall_s2;
        nx.oc_n_s1   = oc_stop_n;
        nx.oc_n_s2   = st.oc_n_s1;
        nx.flt_s1    = drv_fault;
        nx.flt_s2    = st.flt_s1;

        // 1 ms supervision tick
        nx.tick = 1'b0;
        if (st.tick_cnt == 16'(TICK_CYCLES - 1))
        begin
            nx.tick_cnt = '0;
            nx.tick     = 1'b1;
        end
        else
            nx.tick_cnt = 16'(st.tick_cnt + 16'h1);

        // Step period counter saturates rather than wrapping to a false speed
        if (st.per_cnt != '1)
            nx.per_cnt = PER_W'(st.per_cnt + 1'b1);

        // Hardware faults are watched in every state
        new_err[ERR_OC]  = !st.oc_n_s2;
        new_err[ERR_DRV] = st.flt_s2;

        if (st.sys == SYS_ACTIVE)
        begin
            // Bus limits in per-unit, sampled on the tick only
            if (st.tick && vbus_pu > OV_LIMIT_PU)
                new_err[ERR_OV] = 1'b1;
            if (st.tick && vbus_pu < UV_LIMIT_PU)
                new_err[ERR_UV] = 1'b1;

            if (!sensorless_mode)
            begin
                // Hall edge must move exactly one step either way
                if (st.hall_s2 != st.hall_prev)
                begin
                    evt = 1'b1;
                    if (hall_step == step_inc(st.step) || hall_step == step_dec(st.step))
                        nx.step = hall_step;
                    else
                        new_err[ERR_PAT] = 1'b1;
                end
            end
            else
            begin
                case (st.phase)
                    PH_ALIGN:
                    begin
                        // Hold step 0 to pull the rotor in
                        if (st.tick && st.ph_cnt == 8'(ALIGN_TICKS - 1))
                        begin
                            nx.phase  = PH_OPEN;
                            nx.ph_cnt = '0;
                            nx.step   = step_inc(st.step);
                        end
                        else if (st.tick)
                            nx.ph_cnt = 8'(st.ph_cnt + 8'h1);
                    end
                    PH_OPEN:
                    begin
                        if (zc_pulse)
                        begin
                            evt       = 1'b1;
                            nx.zc_cnt = 2'(st.zc_cnt + 2'h1);
                            if (st.zc_cnt == 2'(ZC_TO_CLOSE - 1))
                                nx.phase = PH_CLOSED;
                        end
                        // Forced commutation, blind to rotor position
                        if (st.tick && st.ph_cnt == 8'(OL_STEP_TICKS - 1))
                        begin
                            nx.ph_cnt = '0;
                            nx.step   = step_inc(st.step);
                        end
                        else if (st.tick)
                            nx.ph_cnt = 8'(st.ph_cnt + 8'h1);
                    end
                    PH_CLOSED:
                    begin
                        if (zc_pulse)
                        begin
                            evt     = 1'b1;
                            nx.step = step_inc(st.step);
                        end
                    end
                    default:
                        nx.phase = PH_ALIGN;
                endcase
                if (nx.step > 3'h5)
                    new_err[ERR_PAT] = 1'b1;
            end

            // Commutation watchdog; idle while aligning
            if (evt || (sensorless_mode && st.phase == PH_ALIGN))
                nx.to_cnt = '0;
            else if (st.tick)
            begin
                if (st.to_cnt == 8'(TIMEOUT_TICKS - 1))
                    new_err[ERR_TO] = 1'b1;
                nx.to_cnt = 8'(st.to_cnt + 8'h1);
            end

            // Speed from the interval between two events
            if (evt)
            begin
                // The event cycle counts, so the period spans edge to edge
                nx.per_cnt = PER_W'(1);
                if (st.evt_cnt != 2'h0)
                begin
                    nx.step_period = st.per_cnt;
                    nx.speed_valid = 1'b1;
                end
                if (st.evt_cnt != 2'h2)
                    nx.evt_cnt = 2'(st.evt_cnt + 2'h1);
            end
            if (st.tick && st.speed_valid && st.step_period < PER_W'(OS_STEP_CYCLES))
                new_err[ERR_SPD] = 1'b1;
        end

        // System state; an error detected this cycle beats any command
        case (st.sys)
            SYS_INACTIVE:
            begin
                if (drive_cmd)
                begin
                    nx.sys         = SYS_ACTIVE;
                    nx.to_cnt      = '0;
                    nx.ph_cnt      = '0;
                    nx.zc_cnt      = '0;
                    nx.evt_cnt     = '0;
                    nx.per_cnt     = '0;
                    nx.speed_valid = 1'b0;
                    if (sensorless_mode)
                    begin
                        nx.phase = PH_ALIGN;
                        nx.step  = STEP_RST;
                    end
                    else
                    begin
                        nx.phase = PH_CLOSED;
                        nx.step  = hall_step;
                        if (hall_step > 3'h5)
                            new_err[ERR_PAT] = 1'b1;
                    end
                end
            end
            SYS_ACTIVE:
            begin
                if (stop_cmd)
                    nx.sys = SYS_INACTIVE;
            end
            SYS_ERROR:
            begin
                if (reset_cmd)
                begin
                    nx.sys = SYS_INACTIVE;
                    nx.err = '0;
                end
            end
            default:
                nx.sys = SYS_INACTIVE;
        endcase
        if (new_err != '0)
            nx.sys = SYS_ERROR;
        nx.err = nx.err | new_err;

        // Gates and duty follow the next state so a stop lands in one edge
        nx.gates = (nx.sys == SYS_ACTIVE) ? step_gates(nx.step) : '0;
        nx.duty  = (nx.sys == SYS_ACTIVE) ? div_duty : '0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st          <= '0;
            st.hall_s1  <= 3'h0;
            st.oc_n_s1  <= 1'b1;
            st.oc_n_s2  <= 1'b1;
            st.sys      <= SYS_INACTIVE;
            st.phase    <= PH_ALIGN;
            st.step     <= STEP_RST;
        end
        else if (ce)
            st <= nx;
    end

    assign gates       = st.gates;
    assign duty        = st.duty;
    assign sys_state   = st.sys;
    assign ctl_phase   = st.phase;
    assign err_flags   = st.err;
    assign speed_valid = st.speed_valid;
    assign step_period = st.step_period;

    a_oc_stop: assert property (@(posedge clk) disable iff (rst)
        (ce && !st.oc_n_s2) |=> (gates == '0 && sys_state == SYS_ERROR && err_flags[ERR_OC]))
        else $error("overcurrent did not stop outputs");

    a_drv_fault: assert property (@(posedge clk) disable iff (rst)
        (ce && st.flt_s2) |=> (gates == '0 && err_flags[ERR_DRV]))
        else $error("driver fault did not stop outputs");

    a_ov_check: assert property (@(posedge clk) disable iff (rst)
        (ce && st.tick && st.sys == SYS_ACTIVE && vbus_pu > OV_LIMIT_PU)
        |=> (err_flags[ERR_OV] && sys_state == SYS_ERROR))
        else $error("overvoltage not flagged");

    a_uv_check: assert property (@(posedge clk) disable iff (rst)
        (ce && st.tick && st.sys == SYS_ACTIVE && vbus_pu < UV_LIMIT_PU)
        |=> (err_flags[ERR_UV] && gates == '0))
        else $error("undervoltage not flagged");

    a_speed_limit: assert property (@(posedge clk) disable iff (rst)
        (ce && st.tick && st.sys == SYS_ACTIVE && st.speed_valid
         && st.step_period < PER_W'(OS_STEP_CYCLES)) |=> err_flags[ERR_SPD])
        else $error("overspeed not flagged");

    a_error_gates: assert property (@(posedge clk) disable iff (rst)
        (sys_state != SYS_ACTIVE) |-> (gates == '0 && duty == '0))
        else $error("gates live outside active state");

    a_error_hold: assert property (@(posedge clk) disable iff (rst)
        (sys_state == SYS_ERROR && !reset_cmd) |=> (sys_state == SYS_ERROR && gates == '0
         && (err_flags & $past(err_flags)) == $past(err_flags)))
        else $error("error state left without reset");

    a_hall_start: assert property (@(posedge clk) disable iff (rst)
        (ce && st.sys == SYS_INACTIVE && drive_cmd && !sensorless_mode && new_err == '0)
        |=> (st.step == $past(hall_step) && ctl_phase == PH_CLOSED))
        else $error("hall start pattern wrong");

    a_zc_close: assert property (@(posedge clk) disable iff (rst)
        (ce && st.sys == SYS_ACTIVE && sensorless_mode && st.phase == PH_OPEN
         && zc_pulse && st.zc_cnt == 2'h2 && new_err == '0) |=> (ctl_phase == PH_CLOSED))
        else $error("third zero-crossing did not close loop");

    a_speed_wait: assert property (@(posedge clk) disable iff (rst)
        (ce && st.sys == SYS_INACTIVE && drive_cmd) ##1 (!evt)[*2] |-> !speed_valid)
        else $error("speed valid before two events");

endmodule : bsp_supervisor

// ==== testbench/bsp_motor_model.sv ====
// Stand-in for the motor, Hall sensors, overcurrent circuit and gate driver
`timescale 1ns/100ps
module bsp_motor_model
    import bsp_pkg::*;
(
    input  logic       clk,
    input  bsp_gate_t  gates,
    output logic [2:0] hall_in,
    output logic       zc_pulse,
    output logic       oc_stop_n,
    output logic       drv_fault
);
    // Idle: rotor at step 0, no fault, no overcurrent
    initial
    begin
        hall_in   = 3'h5;
        zc_pulse  = 1'b0;
        oc_stop_n = 1'b1;
        drv_fault = 1'b0;
    end

    task set_hall(input logic [2:0] h);
        hall_in = h;
    endtask : set_hall

    // Comparator pulls the stop line low while over the limit
    task set_oc(input logic over);
        oc_stop_n = ~over;
    endtask : set_oc

    task set_fault(input logic f);
        drv_fault = f;
    endtask : set_fault

    // An unpowered motor makes no back-EMF, so no crossing without drive
    task pulse_zc;
        zc_pulse = (gates != 6'h00);
        @(posedge clk);
        #10;
        zc_pulse = 1'b0;
    endtask : pulse_zc
endmodule : bsp_motor_model

// ==== testbench/bsp_supervisor_tb.sv ====
// Self-checking bench for the start-up and protection supervisor
`timescale 1ns/100ps
module bsp_supervisor_tb;
    import bsp_pkg::*;
    localparam int TK = 20;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ce = 1'b1;
    logic              smode = 1'b0;
    logic              drive_cmd = 1'b0;
    logic              stop_cmd = 1'b0;
    logic              reset_cmd = 1'b0;
    logic [15:0]       vbus_pu = 16'h1000;
    logic [15:0]       vcmd_pu = 16'h0800;
    logic [2:0]        hall_in;
    logic              zc_pulse;
    logic              oc_stop_n;
    logic              drv_fault;
    bsp_gate_t         gates;
    logic [DUTY_W-1:0] duty;
    bsp_sys_t          sys_state;
    bsp_phase_t        ctl_phase;
    logic [ERR_W-1:0]  err_flags;
    logic              speed_valid;
    logic [PER_W-1:0]  step_period;
    int                errors = 0;
    int                comparisons = 0;
    // Hall code and gate pattern of steps 0..5
    logic [2:0]        hc[6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
    logic [5:0]        gt[6] = '{6'h24, 6'h21, 6'h09, 6'h18, 6'h12, 6'h06};

    always #50 clk = ~clk;

    bsp_supervisor #(.TICK_CYCLES(TK), .OS_STEP_CYCLES(40)) u_bsp_supervisor (
        .clk(clk), .rst(rst), .ce(ce), .sensorless_mode(smode),
        .drive_cmd(drive_cmd), .stop_cmd(stop_cmd), .reset_cmd(reset_cmd),
        .hall_in(hall_in), .zc_pulse(zc_pulse), .oc_stop_n(oc_stop_n),
        .drv_fault(drv_fault), .vbus_pu(vbus_pu), .vcmd_pu(vcmd_pu),
        .gates(gates), .duty(duty), .sys_state(sys_state), .ctl_phase(ctl_phase),
        .err_flags(err_flags), .speed_valid(speed_valid), .step_period(step_period));

    bsp_motor_model u_bsp_motor_model (
        .clk(clk), .gates(gates), .hall_in(hall_in), .zc_pulse(zc_pulse),
        .oc_stop_n(oc_stop_n), .drv_fault(drv_fault));

    task close_out;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Inputs always move a fixed 10 ns after the rising edge
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc

    // Bounded wait for one error flag, then the stop must be complete
    task wait_err(input int b, input int lim);
        int i;
        for (i = 0; i < lim && err_flags[b] !== 1'b1; i++)
            cyc(1);
        if (i == lim)
        begin
            errors++;
            close_out();
        end
        check(sys_state, SYS_ERROR);
        check(gates, 6'h00);
    endtask : wait_err

    // Clear the cause; drive must be refused until reset clears the error
    task recover;
        vbus_pu = 16'h1000;
        u_bsp_motor_model.set_oc(1'b0);
        u_bsp_motor_model.set_fault(1'b0);
        u_bsp_motor_model.set_hall(3'h5);
        drive_cmd = 1'b1;
        cyc(3);
        drive_cmd = 1'b0;
        check(sys_state, SYS_ERROR);
        check(gates, 6'h00);
        reset_cmd = 1'b1;
        cyc(1);
        reset_cmd = 1'b0;
        check(sys_state, SYS_INACTIVE);
        check(err_flags, 7'h00);
    endtask : recover

    task start_hall(input int s);
        u_bsp_motor_model.set_hall(hc[s]);
        cyc(3);
        drive_cmd = 1'b1;
        cyc(1);
        drive_cmd = 1'b0;
        check(sys_state, SYS_ACTIVE);
        check(ctl_phase, PH_CLOSED);
        check(gates, gt[s]);
        check(speed_valid, 1'b0);
    endtask : start_hall

    // Two slow Hall steps across the wrap, duty, then silence until timeout
    task hall_run;
        start_hall(4);
        cyc(100);
        u_bsp_motor_model.set_hall(hc[5]);
        cyc(5);
        check(gates, gt[5]);
        check(speed_valid, 1'b0);
        cyc(95);
        u_bsp_motor_model.set_hall(hc[0]);
        cyc(5);
        check(gates, gt[0]);
        check(speed_valid, 1'b1);
        check(step_period, 24'd100);
        check(duty, 10'h200);
        // Command above the bus must saturate the duty
        vcmd_pu = 16'h1400;
        cyc(2 * TK);
        check(duty, 10'h3ff);
        vcmd_pu = 16'h0800;
        cyc(178 * TK);
        check(err_flags, 7'h00);
        wait_err(ERR_TO, 30 * TK);
        check(duty, 10'h000);
        recover();
    endtask : hall_run

    // Skipping a step is an illegal sequence
    task pattern_err;
        start_hall(0);
        cyc(10);
        u_bsp_motor_model.set_hall(hc[2]);
        wait_err(ERR_PAT, 8);
        recover();
    endtask : pattern_err

    // Steps 20 cycles apart are faster than the 40-cycle limit
    task overspeed;
        start_hall(0);
        u_bsp_motor_model.set_hall(hc[1]);
        cyc(20);
        u_bsp_motor_model.set_hall(hc[2]);
        wait_err(ERR_SPD, 3 * TK);
        recover();
    endtask : overspeed

    task volt(input logic [15:0] ok, input logic [15:0] bad, input int b);
        start_hall(0);
        vbus_pu = ok;
        cyc(2 * TK);
        check(err_flags, 7'h00);
        vbus_pu = bad;
        wait_err(b, TK + 4);
        recover();
    endtask : volt

    task trips;
        start_hall(0);
        cyc(10);
        u_bsp_motor_model.set_oc(1'b1);
        wait_err(ERR_OC, 4);
        recover();
        // Clock enable low freezes everything, synchronisers included
        ce = 1'b0;
        u_bsp_motor_model.set_fault(1'b1);
        cyc(6);
        check(err_flags, 7'h00);
        check(sys_state, SYS_INACTIVE);
        ce = 1'b1;
        wait_err(ERR_DRV, 4);
        recover();
    endtask : trips

    // Align, first step into open loop, three crossings to closed loop, then zc stepping
    task sensorless;
        int k;
        smode = 1'b1;
        drive_cmd = 1'b1;
        cyc(1);
        drive_cmd = 1'b0;
        check(ctl_phase, PH_ALIGN);
        check(gates, 6'h24);
        cyc(90 * TK);
        check(ctl_phase, PH_ALIGN);
        for (k = 0; k < 20 * TK && ctl_phase !== PH_OPEN; k++)
            cyc(1);
        check(ctl_phase, PH_OPEN);
        check(gates, 6'h21);
        for (k = 0; k < 3; k++)
        begin
            check(ctl_phase, PH_OPEN);
            u_bsp_motor_model.pulse_zc();
            cyc(1);
        end
        check(ctl_phase, PH_CLOSED);
        for (k = 0; k < 6 && gates !== gt[k]; k++)
            ;
        u_bsp_motor_model.pulse_zc();
        cyc(1);
        check(gates, gt[(k + 1) % 6]);
        stop_cmd = 1'b1;
        cyc(1);
        stop_cmd = 1'b0;
        smode = 1'b0;
        check(sys_state, SYS_INACTIVE);
        check(gates, 6'h00);
    endtask : sensorless

    // Main sequence
    initial
    begin
        cyc(4);
        rst = 1'b0;
        check(gates, 6'h00);
        check(sys_state, SYS_INACTIVE);
        check(err_flags, 7'h00);
        hall_run();
        pattern_err();
        overspeed();
        volt(16'h12aa, 16'h12ab, ERR_OV);
        volt(16'h0a00, 16'h09ff, ERR_UV);
        trips();
        sensorless();
        close_out();
    end
endmodule : bsp_supervisor_tb
